/* File: hw/pma_core.sv */
// macrocell array: product terms, macrocells, power-up reset, preload
// Behaviour
// R1: power-up reset clears all macrocell registers low within the interval.
// R2: after power-up reset, outputs show cleared registers through polarity.
// R3: outside logic keeps the clock pin still during the reset interval.
// R4: outside logic meets setup before the first clock rise after reset.
// R5: preload forces any single macrocell register high or low.
// R6: security fuse blocks configuration readback and refuses preload at once.
// R7: 64-bit user signature stays accessible whether or not secured.
// R8: twelve dedicated inputs and ten macrocells whose outputs feed back.
// R9: each macrocell independently registered or combinatorial, high or low.
// R10: undriven input and I/O pins keep their last driven level.
// R11: registered macrocells capture their sum on the shared clock rise.
module pma_core
    import pma_pkg::*;
#(
    parameter int POR_CYCLES = POR_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_pin,
    input wire logic [NUM_IN-1:0] in_pin,
    input wire logic [NUM_IN-1:0] in_driven,
    input wire logic [NUM_MC-1:0] io_in,
    input wire logic [NUM_MC-1:0] io_driven,
    output logic [NUM_MC-1:0] io_out_q,
    output logic [NUM_MC-1:0] io_oe_q,
    input wire pma_mc_cfg_t [NUM_MC-1:0] mc_cfg,
    input wire logic fuse_secure,
    input wire pma_preload_t preload,
    output logic preload_refused_q,
    input wire logic rb_req,
    input wire logic [MC_SEL_W-1:0] rb_sel,
    output logic rb_valid_q,
    output logic [MODE_W-1:0] rb_mode_q,
    output logic rb_refused_q,
    input wire pma_sig_req_t sig_req,
    output logic [7:0] sig_rdata_q,
    output logic sig_rvalid_q,
    output logic por_busy_q,
    output logic [NUM_MC-1:0] mc_reg_q
);
    // below eight cycles the interval length check cannot hold
    if (POR_CYCLES < 8 || POR_CYCLES >= (1 << POR_CNT_W)) begin : g_chk
        $error("reset interval count out of range");
    end

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);

    pma_state_t state_q;
    logic [POR_CNT_W-1:0] por_cnt_q;
    logic [NUM_IN-1:0] in_meta_q, in_sync_q, ind_meta_q, ind_sync_q;
    logic [NUM_MC-1:0] io_meta_q, io_sync_q, iod_meta_q, iod_sync_q;
    logic [NUM_IN-1:0] in_keep_q;
    logic [NUM_MC-1:0] io_keep_q;
    logic clk_meta_q, clk_sync_q, clk_prev_q;

    // pin synchronisers
    always_ff @(posedge sys_clk) begin
        in_meta_q <= in_pin;
        in_sync_q <= in_meta_q;
        ind_meta_q <= in_driven;
        ind_sync_q <= ind_meta_q;
        io_meta_q <= io_in;
        io_sync_q <= io_meta_q;
        iod_meta_q <= io_driven;
        iod_sync_q <= iod_meta_q;
        clk_meta_q <= clk_pin;
        clk_sync_q <= clk_meta_q;
    end

    wire run = (state_q == PMA_RUN);
    wire por_done = (state_q == PMA_POR) && (por_cnt_q == POR_LAST);
    wire clk_rise = run && clk_sync_q && !clk_prev_q; // [R11] [R3] [R4]

    // pin values seen by the array, with keepers on undriven pins
    wire [NUM_IN-1:0] in_val = (ind_sync_q & in_sync_q) |
                               (~ind_sync_q & in_keep_q); // [R10]
    logic [NUM_MC-1:0] io_oe_cfg, io_val, fb, sum, regd, pol;
    wire [ARR_W-1:0] arr = {fb, in_val}; // [R8]

    for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
        logic [NUM_PT-1:0] term;
        for (genvar p = 0; p < NUM_PT; p++) begin : g_pt
            assign term[p] = mc_cfg[m].pt_use[p] &
                &((~mc_cfg[m].t_true[p] | arr) &
                  (~mc_cfg[m].t_comp[p] | ~arr));
        end
        assign sum[m] = |term;
        assign regd[m] = mc_cfg[m].registered;
        assign pol[m] = mc_cfg[m].active_low;
        assign io_oe_cfg[m] = mc_cfg[m].oe;
        // own drive wins; otherwise outside driver or keeper
        assign io_val[m] = io_oe_q[m] ? io_out_q[m] :
            (iod_sync_q[m] ? io_sync_q[m] : io_keep_q[m]); // [R10]
        // registered cells feed back the register, others the pin
        assign fb[m] = regd[m] ? mc_reg_q[m] : io_val[m]; // [R8] [R9]
    end

    wire pl_ok = run && preload.req && !fuse_secure &&
                 (preload.sel < MC_SEL_W'(NUM_MC)); // [R5] [R6]
    wire pl_bad = preload.req && !pl_ok;
    wire [NUM_MC-1:0] pl_mask = pl_ok ?
        (NUM_MC'(1) << preload.sel) : '0;
    wire [NUM_MC-1:0] cap_val = clk_rise ? sum : mc_reg_q; // [R11]
    wire [NUM_MC-1:0] reg_d = (cap_val & ~pl_mask) |
                              ({NUM_MC{preload.val}} & pl_mask); // [R5]
    wire [NUM_MC-1:0] cell_val = (regd & mc_reg_q) | (~regd & sum); // [R9]
    wire rb_sel_ok = rb_sel < MC_SEL_W'(NUM_MC);
    wire [MODE_W-1:0] rb_mode_d = (fuse_secure || !rb_sel_ok) ? '0 :
        {mc_cfg[rb_sel].oe, mc_cfg[rb_sel].registered,
         mc_cfg[rb_sel].active_low}; // [R6]

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= PMA_POR;
            por_cnt_q <= '0;
        end else if (por_done) begin
            state_q <= PMA_RUN;
        end else if (!run) begin
            por_cnt_q <= por_cnt_q + POR_CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            mc_reg_q <= '0; // [R1]
            io_out_q <= pol; // [R2]
            clk_prev_q <= 1'b1;
        end else begin
            mc_reg_q <= reg_d;
            io_out_q <= cell_val ^ pol; // [R9]
            clk_prev_q <= clk_sync_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_oe_q <= '0;
            in_keep_q <= '0;
            io_keep_q <= '0;
            por_busy_q <= 1'b1;
        end else begin
            io_oe_q <= io_oe_cfg;
            in_keep_q <= in_val; // [R10]
            io_keep_q <= io_val; // [R10]
            por_busy_q <= !run && !por_done;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            preload_refused_q <= 1'b0;
            rb_valid_q <= 1'b0;
            rb_mode_q <= '0;
            rb_refused_q <= 1'b0;
        end else begin
            preload_refused_q <= pl_bad; // [R6]
            rb_valid_q <= rb_req;
            rb_mode_q <= rb_req ? rb_mode_d : '0;
            rb_refused_q <= rb_req && fuse_secure; // [R6]
        end
    end

    // signature access ignores the fuse
    pma_sig_mem #(
        .DEPTH(SIG_BYTES)
    ) u_sig (
        .sys_clk(sys_clk),
        .rst(rst),
        .we(sig_req.we),
        .re(sig_req.re),
        .addr(sig_req.addr),
        .wdata(sig_req.wdata),
        .rdata_q(sig_rdata_q),
        .rvalid_q(sig_rvalid_q)
    ); // [R7]

    a_por_clear_regs: assert property (!run |=> mc_reg_q == '0) // [R1]
        else $error("register not clear during power-up reset");
    a_por_interval_len: assert property ( // [R1]
        $fell(rst) |-> por_busy_q [*8] ##0 !run)
        else $error("power-up reset ended early");
    a_por_out_pol: assert property (!run ##1 !run |-> io_out_q == pol) // [R2]
        else $error("output during reset not polarity of cleared reg");
    a_preload_force: assert property ( // [R5]
        pl_ok |=> mc_reg_q[$past(preload.sel)] == $past(preload.val))
        else $error("preload did not force register");
    a_secure_no_preload: assert property ( // [R6]
        run && preload.req && fuse_secure && !clk_rise |=>
        preload_refused_q && $stable(mc_reg_q))
        else $error("preload accepted while secured");
    a_secure_no_rdback: assert property ( // [R6]
        rb_req && fuse_secure |=> rb_mode_q == '0 && rb_refused_q)
        else $error("configuration readable while secured");
    a_sig_always_read: assert property (sig_req.re |=> sig_rvalid_q) // [R7]
        else $error("signature read not answered");
    a_reg_capture_rise: assert property ( // [R11]
        clk_rise && !pl_ok |=> mc_reg_q == $past(sum))
        else $error("register missed clock rise");
    a_reg_hold_idle: assert property ( // [R11]
        run && !clk_rise && !pl_ok ##1 run |-> $stable(mc_reg_q))
        else $error("register changed without clock rise");
    a_keeper_hold: assert property ( // [R10]
        !ind_sync_q[0] |=> in_keep_q[0] == $past(in_keep_q[0]))
        else $error("keeper lost level on undriven input");
endmodule

/* File: hw/pma_pkg.sv */
// shared constants and types for the macrocell array
package pma_pkg;
    localparam int NUM_IN = 12;
    localparam int NUM_MC = 10;
    localparam int NUM_PT = 8;
    localparam int ARR_W = NUM_IN + NUM_MC;
    localparam int MC_SEL_W = 4;
    localparam int CLK_PERIOD_NS = 5;
    localparam int POR_TYP_NS = 600;
    localparam int POR_MAX_NS = 1000;
    // longest time: round down
    localparam int POR_CYC = POR_MAX_NS / CLK_PERIOD_NS;
    localparam int POR_CNT_W = 8;
    localparam int SIG_BYTES = 8;
    localparam int SIG_ADDR_W = 3;
    localparam logic [7:0] SIG_RESET_DATA = 8'h00;
    localparam int MODE_W = 3;

    typedef struct packed {
        logic [NUM_PT-1:0][ARR_W-1:0] t_true;
        logic [NUM_PT-1:0][ARR_W-1:0] t_comp;
        logic [NUM_PT-1:0] pt_use;
        logic registered;
        logic active_low;
        logic oe;
    } pma_mc_cfg_t;

    typedef struct packed {
        logic req;
        logic [MC_SEL_W-1:0] sel;
        logic val;
    } pma_preload_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [SIG_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } pma_sig_req_t;

    typedef enum logic {
        PMA_POR,
        PMA_RUN
    } pma_state_t;
endpackage

/* File: hw/pma_sig_mem.sv */
// user signature store: small byte memory with registered read data
module pma_sig_mem
    import pma_pkg::*;
#(
    parameter int DEPTH = SIG_BYTES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic we,
    input wire logic re,
    input wire logic [SIG_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_q,
    output logic rvalid_q
);
    if (DEPTH != (1 << SIG_ADDR_W)) begin : g_chk
        $error("signature depth must match its address width");
    end

    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem_q[addr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= SIG_RESET_DATA;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= re;
            if (re) begin
                rdata_q <= mem_q[addr];
            end
        end
    end
endmodule

/* File: sim/pma_board.sv */
// board model: drives the clock pin and the dedicated inputs
module pma_board
    import pma_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic por_busy,
    input wire logic tick,
    input wire logic [NUM_IN-1:0] in_val,
    input wire logic [NUM_IN-1:0] in_drive,
    output logic clk_pin,
    output logic [NUM_IN-1:0] in_pin,
    output logic [NUM_IN-1:0] in_driven
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] ph_q;
    logic [NUM_IN-1:0] last_q;
    // pin stays still while the device is in power-up reset
    always_ff @(posedge sys_clk) begin
        if (rst || por_busy) ph_q <= 4'h0;
        else if (tick && ph_q == 4'h0) ph_q <= 4'h1;
        else if (ph_q != 4'h0) ph_q <= ph_q + 4'h1;
    end
    always_ff @(posedge sys_clk) begin
        last_q <= (in_drive & in_val) | (~in_drive & last_q);
    end
    // inputs settle for four cycles before the rise
    assign clk_pin = ph_q >= 4'h5 && ph_q <= 4'h8;
    // a released pin shows the inverse of its last driven level
    assign in_pin = (in_drive & in_val) | (~in_drive & ~last_q);
    assign in_driven = in_drive;
endmodule

/* File: sim/tb_pma_core.sv */
// self-checking bench for the macrocell array
module tb_pma_core import pma_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [NUM_IN-1:0] iv; logic [NUM_MC-1:0] ov;} pma_row_t;
    pma_row_t rows[4] = '{'{12'h000, 10'h2AA}, '{12'hFFF, 10'h155},
        '{12'h555, 10'h3FF}, '{12'hAAA, 10'h000}};
    logic sys_clk = 0, rst = 1, tick = 0, fuse = 0, rb_req = 0, b;
    logic [NUM_IN-1:0] in_val = '0, in_drive = '1, in_pin, in_driven;
    logic clk_pin, pl_ref, rb_valid, rb_ref, sig_rvalid, por_busy;
    logic [NUM_MC-1:0] io_out_q, io_oe_q, mc_reg_q;
    logic [NUM_MC-1:0] io_lvl = '0, io_drv = '0;
    logic [MC_SEL_W-1:0] rb_sel = '0;
    logic [MODE_W-1:0] rb_mode;
    logic [7:0] sig_rdata;
    pma_mc_cfg_t [NUM_MC-1:0] cfg;
    pma_preload_t pl = '0;
    pma_sig_req_t sr = '0;
    int n_errors = 0, samples_checked = 0, cyc = 0;

    pma_core #(.POR_CYCLES(8)) pma_core_inst (.sys_clk(sys_clk), .rst(rst),
        .clk_pin(clk_pin), .in_pin(in_pin), .in_driven(in_driven),
        .io_in(io_lvl), .io_driven(io_drv),
        .io_out_q(io_out_q), .io_oe_q(io_oe_q),
        .mc_cfg(cfg), .fuse_secure(fuse), .preload(pl),
        .preload_refused_q(pl_ref), .rb_req(rb_req), .rb_sel(rb_sel),
        .rb_valid_q(rb_valid), .rb_mode_q(rb_mode), .rb_refused_q(rb_ref),
        .sig_req(sr), .sig_rdata_q(sig_rdata), .sig_rvalid_q(sig_rvalid),
        .por_busy_q(por_busy), .mc_reg_q(mc_reg_q));
    pma_board pma_board_inst (.sys_clk(sys_clk), .rst(rst),
        .por_busy(por_busy), .tick(tick), .in_val(in_val),
        .in_drive(in_drive), .clk_pin(clk_pin), .in_pin(in_pin),
        .in_driven(in_driven));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // each request starts one edge after the last release
    task automatic preload_do(input logic [3:0] s, input logic v);
        step(1);
        pl = '{1'b1, s, v};
        step(1);
        pl = '0;
    endtask
    task automatic readback(input logic [3:0] s);
        step(1);
        rb_sel = s;
        rb_req = 1;
        step(1);
        rb_req = 0;
    endtask
    task automatic sig(input logic w, input logic [2:0] a,
        input logic [7:0] d);
        step(1);
        sr = '{w, ~w, a, d};
        step(1);
        sr = '0;
    endtask

    initial begin
        for (int i = 0; i < NUM_MC; i++) begin
            cfg[i] = '0;
            cfg[i].t_true[0][i] = 1'b1;
            cfg[i].pt_use = 8'h01;
            cfg[i].registered = (i % 4) >= 2;
            cfg[i].active_low = i[0];
            cfg[i].oe = 1'b1;
        end
        step(3);
        rst = 0;
        step(4);
        check({por_busy, mc_reg_q}, 11'h400);
        check(io_out_q, 10'h2AA);
        step(6);
        check({por_busy, mc_reg_q}, 11'h000);
        check({io_oe_q, io_out_q}, 20'hFFEAA);
        $display("test power-up done");
        for (int r = 0; r < 4; r++) begin
            in_val = rows[r].iv;
            tick = 1;
            step(1);
            tick = 0;
            step(20);
            check(io_out_q, rows[r].ov);
            check(mc_reg_q & 10'h0CC, rows[r].iv[9:0] & 10'h0CC);
        end
        $display("test modes done");
        in_val = '1;
        step(10);
        check(io_out_q, 10'h111);
        in_drive = '0;
        in_val = '0;
        step(10);
        check(io_out_q, 10'h111);
        in_drive = '1;
        $display("test hold and keeper done");
        for (int s = 0; s < NUM_MC; s++) begin
            for (int v = 0; v < 2; v++) begin
                preload_do(4'(s), v[0]);
                check({pl_ref, mc_reg_q[s]}, {1'b0, v[0]});
            end
            readback(4'(s));
            check({rb_valid, rb_mode}, {2'b11, cfg[s].registered,
                cfg[s].active_low});
        end
        preload_do(4'hA, 1'b1);
        check(pl_ref, 1'b1);
        $display("test preload done");
        fuse = 1;
        b = mc_reg_q[0];
        preload_do(4'h0, ~b);
        check({pl_ref, mc_reg_q[0]}, {1'b1, b});
        readback(4'h0);
        check({rb_ref, rb_mode}, 4'h8);
        for (int k = 0; k < 8; k++) sig(1'b1, 3'(k), 8'(8'hA0 + k));
        for (int k = 0; k < 8; k++) begin
            sig(1'b0, 3'(k), 8'h00);
            check({sig_rvalid, sig_rdata}, {1'b1, 8'(8'hA0 + k)});
        end
        fuse = 0;
        $display("test secure done");
        // cell 0 reads I/O pin 1, cell 4 a complement, cell 5 register 2
        step(1);
        cfg[1].oe = 1'b0;
        cfg[0].t_true[0] = '0;
        cfg[0].t_true[0][NUM_IN+1] = 1'b1;
        cfg[4].t_true[0] = '0;
        cfg[4].t_comp[0][4] = 1'b1;
        cfg[5].t_true[0] = '0;
        cfg[5].t_true[0][NUM_IN+2] = 1'b1;
        io_lvl[1] = 1'b1;
        io_drv[1] = 1'b1;
        step(10);
        check({io_oe_q, io_out_q}, {10'h3FD, 10'h257});
        // a released pin reads the inverse; the keeper must hide it
        io_drv[1] = 1'b0;
        io_lvl[1] = 1'b0;
        step(10);
        check(io_out_q, 10'h257);
        preload_do(4'h2, 1'b0);
        step(2);
        check(io_out_q, 10'h273);
        $display("test feedback done");
        rst = 1;
        step(3);
        rst = 0;
        step(4);
        check({por_busy, mc_reg_q}, 11'h400);
        check(io_out_q, 10'h2AA);
        step(6);
        check(por_busy, 1'b0);
        $display("test second reset done");
        test_done();
    end
endmodule
